// File: hw/purs_pkg.sv
/*
  constants, encodings and types shared by the power-up reset sequencer.
  assumes a single 125 MHz clock domain; analog detector outputs arrive
  as asynchronous pins and are synchronised inside the design.
*/
package purs_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS       = 8000;
  localparam int unsigned SUPPLY_SETTLE_MS    = 72;
  // period of the internal rc tick; plain default, tune to the silicon
  localparam int unsigned RC_TICK_US          = 1000;
  localparam int unsigned SUPPLY_SETTLE_TICKS =
    (SUPPLY_SETTLE_MS * 1000) / RC_TICK_US;
  localparam int unsigned OSC_SETTLE_CYCLES   = 1024;
  // least under-voltage time that trips a droop reset; plain default
  localparam int unsigned DROOP_FILTER_NS     = 2000;
  localparam int unsigned DROOP_FILTER_CYC    =
    (DROOP_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W               = 16;

  // ----------------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_FLAGS     = 8'h00;
  localparam logic [7:0] ADDR_CAUSE     = 8'h01;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h02;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h03;
  localparam int unsigned FLAG_DROOP_BIT = 0;
  localparam int unsigned FLAG_POR_BIT   = 1;
  localparam int unsigned IRQ_DROOP      = 0;
  localparam int unsigned IRQ_POR        = 1;
  localparam int unsigned IRQ_RELEASE    = 2;
  localparam int unsigned IRQ_WDT        = 3;
  localparam int unsigned IRQ_W          = 4;

  // cause field is {watchdog_expiry_flag, sleep_entry_flag}
  localparam logic [1:0] CAUSE_RUN      = 2'h3;
  localparam logic [1:0] CAUSE_WDT_RST  = 2'h1;
  localparam logic [1:0] CAUSE_WDT_WAKE = 2'h0;
  localparam logic [1:0] CAUSE_SLEEP    = 2'h2;
  localparam logic [1:0] CAUSE_RST      = 2'h3;
  localparam logic [1:0] FLAGS_RST      = 2'h0;
  localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;

  // ----------------------------------------------------------------------
  // oscillator modes and sequencer states
  // ----------------------------------------------------------------------
  localparam logic [1:0] OSC_LOW_POWER  = 2'h0;
  localparam logic [1:0] OSC_MEDIUM     = 2'h1;
  localparam logic [1:0] OSC_HIGH_SPEED = 2'h2;
  localparam logic [1:0] OSC_RC         = 2'h3;

  typedef enum logic [2:0] {
    S_START, S_SUPPLY, S_OSC, S_RUN, S_SLEEP, S_DROOP
  } purs_seq_t;

  function automatic logic purs_is_crystal(input logic [1:0] mode);
    purs_is_crystal = (mode == OSC_LOW_POWER) || (mode == OSC_MEDIUM) ||
                      (mode == OSC_HIGH_SPEED);
  endfunction

endpackage

// File: hw/purs_edge_cnt.sv
/*
  edge counter: synchronises an asynchronous clock-like pin and counts
  its rising edges up to a target, then holds done until restarted.
  assumes restart and run come from logic on clk.
*/
`timescale 1ns/10ps

module purs_edge_cnt
  import purs_pkg::*;
#(
  parameter int unsigned TARGET = OSC_SETTLE_CYCLES
) (
  // clock, reset, enable
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ce,
  // pin whose edges are counted
  input  wire logic src,
  // control and result
  input  wire logic restart,
  input  wire logic run,
  output logic      done
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(TARGET - 1);

  typedef struct packed {
    logic [2:0]       sync;
    logic [CNT_W-1:0] cnt;
    logic             done;
  } purs_ecnt_t;

  purs_ecnt_t q;
  purs_ecnt_t d;

  // sync[0] feeds only sync[1]; the edge is taken from sync[1] and sync[2]
  always_comb begin
    d      = q;
    d.sync = {q.sync[1:0], src};
    if (restart) begin
      d.cnt  = '0;
      d.done = 1'b0;
    end else if (run && !q.done && q.sync[1] && !q.sync[2]) begin
      d.cnt = q.cnt + 1'b1;
      if (q.cnt == LAST) begin
        d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign done = q.done;

  done_count_a: assert property (@(posedge clk) disable iff (!rst_b)
    (q.done && !$past(q.done)) |-> ($past(q.cnt) == LAST))
    else $error("edge counter finished before its target");

endmodule

// File: hw/purs_top.sv
/*
  power-up and supply-droop reset sequencer: holds the core in reset
  through the supply-settle and oscillator-settle delays, keeps the power
  status flags and the watchdog and sleep cause bits.
  assumes detector outputs, the reset pin, the rc tick and the oscillator
  input are asynchronous pins; configuration bits are static.
*/
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/10ps

module purs_top
  import purs_pkg::*;
#(
  parameter int unsigned SETTLE_TICKS = SUPPLY_SETTLE_TICKS,
  parameter int unsigned OSC_CYCLES   = OSC_SETTLE_CYCLES,
  parameter int unsigned DROOP_FILTER = DROOP_FILTER_CYC,
  parameter bit          DROOP_IMPL   = 1'b1
) (
  // clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  // asynchronous pins
  input  wire logic       por_pulse,
  input  wire logic       under_voltage,
  input  wire logic       external_reset_n,
  input  wire logic       rc_tick,
  input  wire logic       oscillator_input,
  // configuration bits
  input  wire logic       supply_settle_timer_enable_n,
  input  wire logic       droop_detect_enable,
  input  wire logic [1:0] osc_mode,
  // core events
  input  wire logic       wdt_expire,
  input  wire logic       wdt_clear,
  input  wire logic       sleep_enter,
  input  wire logic       int_wake,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_we,
  input  wire logic       reg_re,
  output logic      [7:0] reg_rdata,
  // core control and interrupt
  output logic            core_reset_n,
  output logic            core_sleep,
  output logic            irq
);

  localparam logic [CNT_W-1:0] FILT_MAX = CNT_W'(DROOP_FILTER - 1);

  typedef struct packed {
    logic [2:0]       por_s;
    logic [1:0]       uv_s;
    logic [1:0]       ext_s;
    logic [CNT_W-1:0] filt;
    purs_seq_t        seq;
    logic [1:0]       flags;
    logic [1:0]       cause;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] mask;
    logic [7:0]       rdata;
    logic             core_rst_n;
    logic             sleep;
  } purs_state_t;

  purs_state_t      q;
  purs_state_t      d;
  logic             por_evt;
  logic             uv;
  logic             droop_trip;
  logic             xtal;
  logic             settle_on;
  logic             wdt_hit;
  logic             wake;
  logic             sup_done;
  logic             osc_done;
  logic             sup_restart;
  logic             osc_restart;
  logic [IRQ_W-1:0] irq_set;

  // ----------------------------------------------------------------------
  // settle counters
  // ----------------------------------------------------------------------
  purs_edge_cnt #(
    .TARGET (SETTLE_TICKS)
  ) u_supply_settle_timer (
    .clk     (clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .src     (rc_tick),
    .restart (sup_restart),
    .run     (q.seq == S_SUPPLY),
    .done    (sup_done)
  );

  purs_edge_cnt #(
    .TARGET (OSC_CYCLES)
  ) u_oscillator_settle_timer (
    .clk     (clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .src     (oscillator_input),
    .restart (osc_restart),
    .run     (q.seq == S_OSC),
    .done    (osc_done)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    d          = q;
    por_evt    = q.por_s[1] & ~q.por_s[2];
    uv         = q.uv_s[1] & droop_detect_enable & DROOP_IMPL;
    droop_trip = uv & (q.filt == FILT_MAX);
    xtal       = purs_is_crystal(osc_mode);
    settle_on  = ~supply_settle_timer_enable_n;
    wdt_hit    = 1'b0;
    wake       = 1'b0;
    irq_set    = '0;
    d.por_s    = {q.por_s[1:0], por_pulse};
    d.uv_s     = {q.uv_s[0], under_voltage};
    d.ext_s    = {q.ext_s[0], external_reset_n};
    d.rdata    = 8'h00;

    // short dips never reach the end of the filter
    if (!uv) begin
      d.filt = '0;
    end else if (q.filt != FILT_MAX) begin
      d.filt = q.filt + 1'b1;
    end

    // software access; hardware updates below take precedence
    if (reg_we) begin
      case (reg_addr)
        ADDR_FLAGS:    d.flags  = reg_wdata[1:0];
        ADDR_IRQ_STAT: d.irq_st = q.irq_st & ~reg_wdata[IRQ_W-1:0];
        ADDR_IRQ_MASK: d.mask   = reg_wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    if (reg_re) begin
      case (reg_addr)
        ADDR_FLAGS:    d.rdata = {6'h00, q.flags};
        ADDR_CAUSE:    d.rdata = {6'h00, q.cause};
        ADDR_IRQ_STAT: d.rdata = {4'h0, q.irq_st};
        ADDR_IRQ_MASK: d.rdata = {4'h0, q.mask};
        default:       d.rdata = 8'h00;
      endcase
    end

    // the reset pin gates the core, wakes the sequence from S_SLEEP and sets the cause to CAUSE_RUN in S_RUN; otherwise the sequence ignores it
    if (por_evt) begin
      d.seq = S_START;
    end else if (droop_trip && q.seq != S_DROOP) begin
      d.seq                   = S_DROOP;
      d.flags[FLAG_DROOP_BIT] = 1'b0;
      d.cause                 = CAUSE_RUN;
      irq_set[IRQ_DROOP]      = 1'b1;
    end else begin
      unique case (q.seq)
        S_START: begin
          d.flags[FLAG_POR_BIT] = 1'b0;
          d.cause               = CAUSE_RST;
          irq_set[IRQ_POR]      = 1'b1;
          // rc mode with the timer off releases with no delay
          d.seq = settle_on ? S_SUPPLY : xtal ? S_OSC : S_RUN;
        end
        S_DROOP: begin
          if (!uv) begin
            d.seq = settle_on ? S_SUPPLY : (xtal ? S_OSC : S_RUN);
          end
        end
        S_SUPPLY: begin
          if (uv) begin
            d.seq                   = S_DROOP;
            d.flags[FLAG_DROOP_BIT] = 1'b0;
            irq_set[IRQ_DROOP]      = 1'b1;
          end else if (sup_done) begin
            d.seq = xtal ? S_OSC : S_RUN;
          end
        end
        S_OSC: begin
          if (osc_done) begin
            d.seq = S_RUN;
          end
        end
        S_RUN: begin
          if (wdt_expire) begin
            d.cause          = CAUSE_WDT_RST;
            wdt_hit          = 1'b1;
            irq_set[IRQ_WDT] = 1'b1;
          end else if (sleep_enter) begin
            d.seq   = S_SLEEP;
            d.cause = CAUSE_SLEEP;
          end else if (!q.ext_s[1] || wdt_clear) begin
            d.cause = CAUSE_RUN;
          end
        end
        S_SLEEP: begin
          if (wdt_expire) begin
            d.cause          = CAUSE_WDT_WAKE;
            irq_set[IRQ_WDT] = 1'b1;
            wake             = 1'b1;
          end else if (int_wake || !q.ext_s[1]) begin
            d.cause = CAUSE_SLEEP;
            wake    = 1'b1;
          end
          if (wake) begin
            d.seq = xtal ? S_OSC : S_RUN;
          end
        end
      endcase
    end

    if (d.seq == S_RUN && q.seq != S_RUN && q.seq != S_SLEEP) begin
      irq_set[IRQ_RELEASE] = 1'b1;
    end
    // a clear and an event in one cycle keep the event
    d.irq_st = d.irq_st | irq_set;
    // the droop flag bit does not exist on variants without detection
    if (!DROOP_IMPL) begin
      d.flags[FLAG_DROOP_BIT] = 1'b0;
    end
    // while detection is off the droop flag is left alone and undefined
    d.core_rst_n = (q.seq == S_RUN || q.seq == S_SLEEP) && q.ext_s[1] &&
                   !wdt_hit && !por_evt;
    d.sleep      = (d.seq == S_SLEEP);
  end

  assign sup_restart = (d.seq == S_SUPPLY) && (q.seq != S_SUPPLY);
  assign osc_restart = (d.seq == S_OSC) && (q.seq != S_OSC);

  // ----------------------------------------------------------------------
  // state register and outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q       <= '0;
      q.seq   <= S_START;
      q.flags <= FLAGS_RST;
      q.cause <= CAUSE_RST;
      q.mask  <= MASK_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  assign reg_rdata    = q.rdata;
  assign core_reset_n = q.core_rst_n;
  assign core_sleep   = q.sleep;
  assign irq          = |(q.irq_st & q.mask);

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  supply_start_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && q.seq == S_START && !por_evt && !droop_trip && settle_on)
      |=> (q.seq == S_SUPPLY))
    else $error("power-on did not start the supply-settle timer");

  hold_supply_a: assert property (@(posedge clk) disable iff (!rst_b)
    (q.seq == S_SUPPLY) |=> !core_reset_n)
    else $error("core left reset during the supply-settle delay");

  skip_supply_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && q.seq != S_SUPPLY && !settle_on && !uv) |=> (q.seq != S_SUPPLY))
    else $error("disabled supply-settle timer was started");

  osc_after_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && q.seq == S_SUPPLY && sup_done && !uv && !por_evt && xtal)
      |=> (q.seq == S_OSC) ##1 !core_reset_n)
    else $error("oscillator count did not follow the supply delay");

  rc_no_osc_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && q.seq != S_OSC && !xtal) |=> (q.seq != S_OSC))
    else $error("oscillator count entered in rc mode");

  droop_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && !droop_detect_enable && q.seq != S_DROOP) |=> (q.seq != S_DROOP))
    else $error("droop reset with detection disabled");

  droop_enter_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && droop_trip && !por_evt) |=> (q.seq == S_DROOP) ##1 !core_reset_n)
    else $error("filtered under-voltage did not reset the chip");

  droop_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && q.seq == S_DROOP && !uv && !por_evt && settle_on)
      |=> (q.seq == S_SUPPLY))
    else $error("droop release did not restart the supply delay");

  droop_again_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && q.seq == S_SUPPLY && uv && !por_evt) |=> (q.seq == S_DROOP))
    else $error("under-voltage in supply delay did not re-enter droop");

  rc_no_delay_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && q.seq == S_START && !por_evt && !droop_trip && !settle_on && !xtal)
      |=> (q.seq == S_RUN))
    else $error("rc mode without timer still delayed release");

  pin_gates_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && !q.ext_s[1]) |=> !core_reset_n)
    else $error("core left reset while the reset pin was low");

  droop_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && droop_trip && !por_evt) |=> !q.flags[FLAG_DROOP_BIT])
    else $error("droop reset left the droop flag set");

  por_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && q.seq == S_START && !por_evt && !droop_trip)
      |=> !q.flags[FLAG_POR_BIT])
    else $error("power-on did not clear the power-on flag");

  flag_absent_a: assert property (@(posedge clk) disable iff (!rst_b)
    !DROOP_IMPL |-> !q.flags[FLAG_DROOP_BIT])
    else $error("unimplemented droop flag bit reads as one");

  cause_wdt_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && q.seq == S_RUN && wdt_expire && !por_evt && !droop_trip)
      |=> (q.cause == CAUSE_WDT_RST) && !core_reset_n)
    else $error("watchdog reset gave the wrong cause code");

endmodule

// File: sim/purs_far_model.sv
/*
  far-side model: power-on and droop detectors, reset pin, free-running
  rc tick and oscillator input.
  assumes the bench sets the request levels by non-blocking assignment.
*/
`timescale 1ns/10ps

module purs_far_model (
  // bench side
  input  wire logic clk,
  input  wire logic por_req,
  input  wire logic uv_req,
  input  wire logic pin_req,
  // pins towards the sequencer
  output logic      por_pulse,
  output logic      under_voltage,
  output logic      external_reset_n,
  output logic      rc_tick,
  output logic      oscillator_input
);
  // ----------------------------------------------------------------------
  // oscillators
  // ----------------------------------------------------------------------
  // both stay slower than clk/2 so no edge is lost in the synchroniser
  int   rc_n = 0;
  int   os_n = 0;
  logic rc_q = 1'b0;
  logic os_q = 1'b0;

  always @(posedge clk) begin
    rc_n <= (rc_n == 2) ? 0 : rc_n + 1;
    os_n <= (os_n == 1) ? 0 : os_n + 1;
    if (rc_n == 2) rc_q <= ~rc_q;
    if (os_n == 1) os_q <= ~os_q;
  end

  assign rc_tick          = rc_q;
  assign oscillator_input = os_q;
  assign por_pulse        = por_req;
  assign under_voltage    = uv_req;
  assign external_reset_n = pin_req;
endmodule

// File: sim/power_up_reset_sequencer_tb_top.sv
/*
  self-checking bench for the reset sequencer: release windows, flags,
  cause bits, droop handling and the register port.
  assumes purs_top and purs_far_model; rc period 6, osc period 4 clocks.
*/
`timescale 1ns/10ps

module power_up_reset_sequencer_tb_top;
  import purs_pkg::*;
  localparam int TK = 4;
  localparam int OC = 8;

  logic       clk = 1'b0;
  logic       rst_b, ce, por_req, uv_req, pin_req, tmr_n, droop_en;
  logic [1:0] osc_mode;
  logic [3:0] ev;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic       reg_we, reg_re, core_reset_n, core_sleep, irq;
  logic       por_p, uv, pin_n, rc, osc;
  int         failures = 0;
  int         n_checks = 0;
  int         lo;
  int         hi;
  // model of the power status flags, kept from the rules
  int         m_flags;

  always #4 clk = ~clk;

  purs_far_model far (.clk(clk), .por_req(por_req), .uv_req(uv_req),
    .pin_req(pin_req), .por_pulse(por_p), .under_voltage(uv),
    .external_reset_n(pin_n), .rc_tick(rc), .oscillator_input(osc));

  purs_top #(.SETTLE_TICKS(TK), .OSC_CYCLES(OC), .DROOP_FILTER(3),
    .DROOP_IMPL(1'b1)) dut (.clk(clk), .rst_b(rst_b), .ce(ce),
    .por_pulse(por_p), .under_voltage(uv), .external_reset_n(pin_n),
    .rc_tick(rc), .oscillator_input(osc),
    .supply_settle_timer_enable_n(tmr_n), .droop_detect_enable(droop_en),
    .osc_mode(osc_mode), .wdt_expire(ev[3]), .wdt_clear(ev[2]),
    .sleep_enter(ev[1]), .int_wake(ev[0]), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .core_reset_n(core_reset_n),
    .core_sleep(core_sleep), .irq(irq));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_we <= 1'b0;
    if (a == ADDR_FLAGS) m_flags = int'(v[1:0]);
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp,
                      input string what);
    @(posedge clk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 check(what, reg_rdata, exp);
  endtask

  task automatic pulse(input logic [3:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 4'h0;
  endtask

  task automatic do_reset(input logic [1:0] m, input logic t,
                          input logic de);
    @(posedge clk);
    rst_b    <= 1'b0;
    osc_mode <= m;
    tmr_n    <= t;
    droop_en <= de;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    // release acts as a power-on, which clears the power-on flag
    m_flags = int'(FLAGS_RST);
    m_flags[FLAG_POR_BIT] = 1'b0;
  endtask

  // core reset must lift no earlier than lo and no later than hi cycles
  task automatic wait_rel(input string what, input int l, input int h);
    int n;
    n = 0;
    while (core_reset_n !== 1'b1 && n <= h) begin
      @(posedge clk);
      n++;
    end
    check(what, 8'((n >= l) && (n <= h)), 8'h01);
    if (n > h) report_and_stop();
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    {rst_b, por_req, uv_req, reg_we, reg_re, tmr_n} = 6'h00;
    {ce, pin_req, droop_en} = 3'h7;
    {osc_mode, ev, reg_addr, reg_wdata} = 22'h0;
    void'($urandom(47));
    for (int i = 0; i < 8; i++) begin
      // droop detection only beside an enabled supply timer
      do_reset(i[1:0], i[2], !i[2]);
      lo = (i[2] ? 0 : (TK - 1) * 6) + (i[1:0] != OSC_RC ? (OC - 1) * 4 : 0);
      hi = lo + 14 + (i[2] ? 0 : 6);
      wait_rel("rel", lo, hi);
      rchk(ADDR_FLAGS, 8'(m_flags), "flags_por");
      rchk(ADDR_CAUSE, {6'h0, CAUSE_RUN}, "cause_por");
      rchk(ADDR_IRQ_STAT, 8'h06, "irq_stat");
    end
    // timer enabled whenever droop detection is on
    do_reset(OSC_MEDIUM, 1'b0, 1'b1);
    lo = (TK - 1) * 6 + (OC - 1) * 4;
    wait_rel("release_xtal", lo, lo + 20);
    d = 8'($urandom);
    wr(ADDR_FLAGS, d);
    rchk(ADDR_FLAGS, {6'h0, d[1:0]}, "flags_rw");
    rchk(8'h7F, 8'h00, "unmapped");
    wr(ADDR_IRQ_STAT, 8'hFF);
    rchk(ADDR_IRQ_STAT, 8'h00, "irq_w1c");
    wr(ADDR_FLAGS, 8'h03);
    wr(ADDR_IRQ_MASK, 8'h01);
    // a short dip is filtered, a long one trips the reset
    @(posedge clk) uv_req <= 1'b1;
    repeat (2) @(posedge clk);
    uv_req <= 1'b0;
    repeat (10) @(posedge clk);
    check("dip", {7'h0, core_reset_n}, 8'h01);
    uv_req <= 1'b1;
    repeat (8) @(posedge clk);
    check("droop_rst", {7'h0, core_reset_n}, 8'h00);
    check("droop_irq", {7'h0, irq}, 8'h01);
    repeat (30) @(posedge clk);
    check("droop_hold", {7'h0, core_reset_n}, 8'h00);
    uv_req <= 1'b0;
    // dip again while the supply timer runs: it must start over
    repeat (15) @(posedge clk);
    uv_req <= 1'b1;
    repeat (3) @(posedge clk);
    uv_req <= 1'b0;
    wait_rel("droop_release", lo, lo + 24);
    m_flags[FLAG_DROOP_BIT] = 1'b0;
    rchk(ADDR_FLAGS, 8'(m_flags), "flags_droop");
    wr(ADDR_IRQ_STAT, 8'h01);
    #1 check("irq_clear", {7'h0, irq}, 8'h00);
    // power-on with the pin held low: delays expire behind the pin
    wr(ADDR_FLAGS, 8'h03);
    pin_req <= 1'b0;
    por_req <= 1'b1;
    repeat (3) @(posedge clk);
    por_req <= 1'b0;
    repeat (120) @(posedge clk);
    check("pin_hold", {7'h0, core_reset_n}, 8'h00);
    pin_req <= 1'b1;
    repeat (4) @(posedge clk);
    check("pin_go", {7'h0, core_reset_n}, 8'h01);
    m_flags[FLAG_POR_BIT] = 1'b0;
    rchk(ADDR_FLAGS, 8'(m_flags), "flags_por2");
    // cause codes through watchdog and sleep
    pulse(4'h8);
    rchk(ADDR_CAUSE, {6'h0, CAUSE_WDT_RST}, "cause_wdt");
    pulse(4'h4);
    rchk(ADDR_CAUSE, {6'h0, CAUSE_RUN}, "cause_clr");
    pulse(4'h2);
    rchk(ADDR_CAUSE, {6'h0, CAUSE_SLEEP}, "cause_sleep");
    check("sleeping", {7'h0, core_sleep}, 8'h01);
    pulse(4'h8);
    rchk(ADDR_CAUSE, {6'h0, CAUSE_WDT_WAKE}, "cause_wake");
    repeat (60) @(posedge clk);
    check("woken", {7'h0, core_sleep}, 8'h00);
    check("woken_run", {7'h0, core_reset_n}, 8'h01);
    pulse(4'h2);
    pulse(4'h1);
    rchk(ADDR_CAUSE, {6'h0, CAUSE_SLEEP}, "cause_int");
    // detection disabled: a long under-voltage leaves the core running
    do_reset(OSC_RC, 1'b1, 1'b0);
    wait_rel("release_rc", 0, 14);
    uv_req <= 1'b1;
    repeat (20) @(posedge clk);
    check("droop_off", {7'h0, core_reset_n}, 8'h01);
    uv_req <= 1'b0;
    report_and_stop();
  end
endmodule
